/* hw/ibt_events.sv */
// Purpose: Sticky interrupt causes with a combined request output.
// Assumes: Set and clear strobes are one-cycle pulses on clk.
// Notes: A set in the same cycle as its clear wins.
`timescale 1ns/10ps
module ibt_events
    import ibt_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [EVT_COUNT-1:0] set,
    input wire logic [EVT_COUNT-1:0] clear,
    output logic [EVT_COUNT-1:0] pending,
    output logic irq
);

    genvar i;
    generate
        for (i = 0; i < EVT_COUNT; i++) begin : g_evt
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    pending[i] <= 1'b0;
                end else if (set[i]) begin
                    pending[i] <= 1'b1;
                end else if (clear[i]) begin
                    pending[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Registered so the request pin is glitch free; it is built from set and clear so it tracks pending with no lag.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pending & ~clear) | (|set);
        end
    end

endmodule : ibt_events

/* hw/ibt_pkg.sv */
// Purpose: Shared constants for the instrument bus talker/listener.
// Assumes: Bus lines are presented active high (negative pin logic inverted outside).
// Notes: Command codes follow the standard bus message encoding.
package ibt_pkg;

    localparam logic [7:0] CMD_GTL = 8'h01;
    localparam logic [7:0] CMD_SDC = 8'h04;
    localparam logic [7:0] CMD_GET = 8'h08;
    localparam logic [7:0] CMD_DCL = 8'h14;
    localparam logic [7:0] CMD_SPE = 8'h18;
    localparam logic [7:0] CMD_SPD = 8'h19;
    localparam logic [7:0] CMD_UNL = 8'h3f;
    localparam logic [7:0] CMD_UNT = 8'h5f;
    localparam logic [2:0] GRP_UCG = 3'h1;
    localparam logic [2:0] GRP_LAG = 3'h2;
    localparam logic [2:0] GRP_LAG2 = 3'h3;
    localparam logic [2:0] GRP_TAG = 3'h4;
    localparam logic [2:0] GRP_TAG2 = 3'h5;
    localparam logic [4:0] ADDR_MASK_ALL = 5'h1f;

    localparam int EVT_COUNT = 6;
    localparam int EVT_DATA_IN = 0;
    localparam int EVT_DATA_OUT = 1;
    localparam int EVT_CLEAR = 2;
    localparam int EVT_TRIGGER = 3;
    localparam int EVT_POLL = 4;
    localparam int EVT_RLC = 5;

    typedef enum logic [1:0] {
        IBT_AH_IDLE = 2'b00,
        IBT_AH_READY = 2'b01,
        IBT_AH_ACCEPT = 2'b10,
        IBT_AH_WAIT = 2'b11
    } ibt_ah_t;

    typedef enum logic [1:0] {
        IBT_SH_IDLE = 2'b00,
        IBT_SH_SETTLE = 2'b01,
        IBT_SH_VALID = 2'b10,
        IBT_SH_DONE = 2'b11
    } ibt_sh_t;

endpackage : ibt_pkg

/* hw/ibt_sync.sv */
// Purpose: Three-stage synchroniser for bus lines, change on agreement.
// Assumes: Inputs are asynchronous to clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
module ibt_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit only moves once the later two stages agree, filtering one-cycle glitches.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    dout[i] <= 1'b0;
                end else if (stage2[i] == stage3[i]) begin
                    dout[i] <= stage3[i];
                end
            end
        end
    endgenerate

endmodule : ibt_sync

/* hw/ibt_talker_listener.sv */
// Purpose: Bus talker/listener with hardware addressing and handshake.
// Assumes: Bus lines active high inside; open-drain pins use low-true enables.
// Notes: Processor port is a simple strobe interface on clk.
`timescale 1ns/10ps
module ibt_talker_listener
    import ibt_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] my_address,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic bus_data_oe_n,
    input wire logic bus_atn,
    input wire logic bus_ren,
    input wire logic bus_ifc,
    input wire logic bus_dav_in,
    output logic bus_dav_out,
    output logic bus_dav_oe_n,
    input wire logic bus_nrfd_in,
    output logic bus_nrfd_out,
    output logic bus_nrfd_oe_n,
    input wire logic bus_ndac_in,
    output logic bus_ndac_out,
    output logic bus_ndac_oe_n,
    input wire logic cpu_read,
    output logic [7:0] cpu_data_in,
    input wire logic cpu_write,
    input wire logic [7:0] cpu_data_out,
    input wire logic [EVT_COUNT-1:0] cpu_ack,
    output logic [EVT_COUNT-1:0] event_pending,
    output logic remote,
    output logic talker,
    output logic listener,
    output logic irq
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [7:0] s_data;
    logic s_atn;
    logic s_ren;
    logic s_ifc;
    logic s_dav;
    logic s_nrfd;
    logic s_ndac;

    ibt_sync #(.WIDTH(14)) u_sync (
        .clk(clk),
        .reset(reset),
        .din({bus_data_in, bus_atn, bus_ren, bus_ifc, bus_dav_in, bus_nrfd_in, bus_ndac_in}),
        .dout({s_data, s_atn, s_ren, s_ifc, s_dav, s_nrfd, s_ndac})
    );

    // ------------------------------------------------------------------
    // Acceptor handshake
    // ------------------------------------------------------------------
    ibt_ah_t ah_state;
    logic byte_strobe;
    logic [7:0] rx_byte;
    logic rx_atn;
    logic in_full;
    logic ah_active;
    logic tx_taken;

    // Commands are always accepted; data only when addressed to listen.
    // Autonomous acceptance.
    assign ah_active = s_atn | listener;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ah_state <= IBT_AH_IDLE;
            byte_strobe <= 1'b0;
            rx_byte <= 8'h00;
            rx_atn <= 1'b0;
        end else begin
            byte_strobe <= 1'b0;
            case (ah_state)
                IBT_AH_IDLE: begin
                    if (ah_active && !s_dav && (s_atn || !in_full)) begin
                        ah_state <= IBT_AH_READY;
                    end
                end
                IBT_AH_READY: begin
                    // A full input register withdraws readiness once the command phase ends.
                    if (!ah_active || (!s_atn && in_full)) begin
                        ah_state <= IBT_AH_IDLE;
                    end else if (s_dav) begin
                        rx_byte <= s_data;
                        rx_atn <= s_atn;
                        byte_strobe <= 1'b1;
                        ah_state <= IBT_AH_ACCEPT;
                    end
                end
                IBT_AH_ACCEPT: begin
                    ah_state <= IBT_AH_WAIT;
                end
                IBT_AH_WAIT: begin
                    if (!s_dav) begin
                        ah_state <= IBT_AH_IDLE;
                    end
                end
                default: begin
                    ah_state <= IBT_AH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_nrfd_out <= 1'b0;
            bus_nrfd_oe_n <= 1'b1;
            bus_ndac_out <= 1'b0;
            bus_ndac_oe_n <= 1'b1;
        end else begin
            bus_nrfd_out <= 1'b1;
            bus_ndac_out <= 1'b1;
            bus_nrfd_oe_n <= !(ah_active && ah_state != IBT_AH_READY);
            bus_ndac_oe_n <= !(ah_active && ah_state != IBT_AH_WAIT);
        end
    end

    // ------------------------------------------------------------------
    // Command decoding and addressing
    // ------------------------------------------------------------------
    logic is_cmd;
    logic is_universal;
    logic is_addressed_cmd;
    logic my_listen;
    logic my_talk;
    logic [EVT_COUNT-1:0] evt_set;
    logic [EVT_COUNT-1:0] evt_clear;

    assign is_cmd = byte_strobe && rx_atn;
    assign is_universal = is_cmd && (rx_byte[6:4] == GRP_UCG);
    assign is_addressed_cmd = is_cmd && (rx_byte[6:4] == 3'h0) && listener;
    assign my_listen = is_cmd && (rx_byte[6:5] == GRP_LAG[2:1])
        && (rx_byte[4:0] == my_address) && (my_address != ADDR_MASK_ALL);
    assign my_talk = is_cmd && (rx_byte[6:5] == GRP_TAG[2:1])
        && (rx_byte[4:0] == my_address) && (my_address != ADDR_MASK_ALL);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            listener <= 1'b0;
            talker <= 1'b0;
        end else if (s_ifc) begin
            listener <= 1'b0;
            talker <= 1'b0;
        end else if (is_cmd) begin
            if (my_listen) begin
                listener <= 1'b1;
            end else if ({1'b0, rx_byte[6:0]} == CMD_UNL) begin
                listener <= 1'b0;
            end
            if (my_talk) begin
                talker <= 1'b1;
            end else if ((rx_byte[6:5] == GRP_TAG[2:1]) || ({1'b0, rx_byte[6:0]} == CMD_UNT)) begin
                talker <= 1'b0;
            end
        end
    end

    logic ren_prev;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            remote <= 1'b0;
            ren_prev <= 1'b0;
        end else begin
            ren_prev <= s_ren;
            if (!s_ren) begin
                remote <= 1'b0;
            end else if (my_listen) begin
                remote <= 1'b1;
            end else if (is_addressed_cmd && {1'b0, rx_byte[6:0]} == CMD_GTL) begin
                remote <= 1'b0;
            end
        end
    end

    // Only chosen commands reach the processor as events.
    always_comb begin
        evt_set = '0;
        evt_set[EVT_DATA_IN] = byte_strobe && !rx_atn;
        evt_set[EVT_DATA_OUT] = tx_taken;
        evt_set[EVT_CLEAR] = (is_universal && {1'b0, rx_byte[6:0]} == CMD_DCL)
            || (is_addressed_cmd && {1'b0, rx_byte[6:0]} == CMD_SDC);
        evt_set[EVT_TRIGGER] = is_addressed_cmd && {1'b0, rx_byte[6:0]} == CMD_GET;
        evt_set[EVT_POLL] = is_universal
            && ({1'b0, rx_byte[6:0]} == CMD_SPE || {1'b0, rx_byte[6:0]} == CMD_SPD);
        // Remote enable dropped; go-to-local; listen while local.
        evt_set[EVT_RLC] = (ren_prev && !s_ren)
            || (remote && is_addressed_cmd && {1'b0, rx_byte[6:0]} == CMD_GTL)
            || (!remote && s_ren && my_listen);
    end

    always_comb begin
        evt_clear = cpu_ack;
        evt_clear[EVT_DATA_IN] = cpu_read;
        evt_clear[EVT_DATA_OUT] = cpu_write;
    end

    ibt_events u_events (
        .clk(clk),
        .reset(reset),
        .set(evt_set),
        .clear(evt_clear),
        .pending(event_pending),
        .irq(irq)
    );

    // ------------------------------------------------------------------
    // Data-in register
    // ------------------------------------------------------------------
    // Data byte forwarding.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cpu_data_in <= 8'h00;
            in_full <= 1'b0;
        end else if (byte_strobe && !rx_atn) begin
            cpu_data_in <= rx_byte;
            in_full <= 1'b1;
        end else if (cpu_read) begin
            in_full <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Source handshake
    // ------------------------------------------------------------------
    ibt_sh_t sh_state;
    logic out_full;
    logic [7:0] out_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_reg <= 8'h00;
        end else if (cpu_write) begin
            out_reg <= cpu_data_out;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sh_state <= IBT_SH_IDLE;
            out_full <= 1'b0;
            tx_taken <= 1'b0;
        end else begin
            tx_taken <= 1'b0;
            if (cpu_write) begin
                out_full <= 1'b1;
            end
            case (sh_state)
                IBT_SH_IDLE: begin
                    if (talker && !s_atn && out_full) begin
                        sh_state <= IBT_SH_SETTLE;
                    end
                end
                IBT_SH_SETTLE: begin
                    if (s_atn || !talker) begin
                        sh_state <= IBT_SH_IDLE;
                    end else if (!s_nrfd) begin
                        sh_state <= IBT_SH_VALID;
                    end
                end
                IBT_SH_VALID: begin
                    if (!s_ndac) begin
                        sh_state <= IBT_SH_DONE;
                        out_full <= cpu_write;
                        tx_taken <= 1'b1;
                    end
                end
                IBT_SH_DONE: begin
                    sh_state <= IBT_SH_IDLE;
                end
                default: begin
                    sh_state <= IBT_SH_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_data_out <= 8'h00;
            bus_data_oe_n <= 1'b1;
            bus_dav_out <= 1'b0;
            bus_dav_oe_n <= 1'b1;
        end else begin
            bus_data_out <= out_reg;
            bus_data_oe_n <= !(sh_state == IBT_SH_SETTLE || sh_state == IBT_SH_VALID);
            bus_dav_out <= 1'b1;
            bus_dav_oe_n <= !(sh_state == IBT_SH_VALID);
        end
    end

endmodule : ibt_talker_listener

/* testbench/ibt_ctrl_model.sv */
// Purpose: Bus controller and far instrument for the talker/listener.
// Assumes: Lines active high; a released line reads 0 through its pull-up.
// Notes: The bench calls one task at a time; recv may run beside processor writes.
`timescale 1ns/10ps
module ibt_ctrl_model (
    input wire logic clk,
    input wire logic [7:0] bus_data_out,
    input wire logic bus_data_oe_n,
    input wire logic bus_dav_out,
    input wire logic bus_dav_oe_n,
    input wire logic bus_nrfd_out,
    input wire logic bus_nrfd_oe_n,
    input wire logic bus_ndac_out,
    input wire logic bus_ndac_oe_n,
    output logic [7:0] bus_data_in,
    output logic bus_dav_in,
    output logic bus_nrfd_in,
    output logic bus_ndac_in,
    output logic bus_atn,
    output logic bus_ren,
    output logic bus_ifc
);
    logic [7:0] m_data = 8'h00;
    logic m_dav = 1'b0;
    logic m_nrfd = 1'b0;
    logic m_ndac = 1'b0;

    // Every data and handshake line is a wired OR of both parties.
    assign bus_data_in = m_data | (bus_data_oe_n ? 8'h00 : bus_data_out);
    assign bus_dav_in = m_dav | (!bus_dav_oe_n && bus_dav_out);
    assign bus_nrfd_in = m_nrfd | (!bus_nrfd_oe_n && bus_nrfd_out);
    assign bus_ndac_in = m_ndac | (!bus_ndac_oe_n && bus_ndac_out);

    initial begin
        bus_atn = 1'b0;
        bus_ren = 1'b0;
        bus_ifc = 1'b0;
    end

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic send(input logic [7:0] b, input logic a, output bit ok);
        int i;
        ok = 1'b0;
        m_nrfd = 1'b0;
        bus_atn = a;
        m_data = b;
        // Give the far side's synchronisers time to react before judging its readiness.
        repeat (8) step();
        for (i = 0; i < 60 && bus_nrfd_in; i++) step();
        if (!bus_nrfd_in) begin
            m_dav = 1'b1;
            repeat (4) step();
            for (i = 0; i < 60 && bus_ndac_in; i++) step();
            ok = !bus_ndac_in;
        end
        m_dav = 1'b0;
        m_data = 8'h00;
        repeat (4) step();
    endtask : send

    task automatic recv(output logic [7:0] b, input int slow, output bit ok);
        int i;
        m_nrfd = 1'b1;
        m_ndac = 1'b1;
        repeat (slow) step();
        m_nrfd = 1'b0;
        for (i = 0; i < 80 && !bus_dav_in; i++) step();
        repeat (slow) step();
        b = bus_data_in;
        ok = bus_dav_in;
        m_nrfd = 1'b1;
        m_ndac = 1'b0;
        for (i = 0; i < 80 && bus_dav_in; i++) step();
        ok = ok && !bus_dav_in;
        // Stay not ready until the next byte is wanted; readiness may not be withdrawn.
    endtask : recv
endmodule : ibt_ctrl_model

/* testbench/ibt_talker_listener_sva.sv */
// Purpose: Port-level checks for the bus talker/listener.
// Assumes: Bench keeps the bus quiet while the processor clears an event.
// Notes: Bound to every instance of the top module.
`timescale 1ns/10ps
module ibt_tl_sva
    import ibt_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic bus_atn,
    input wire logic bus_nrfd_in,
    input wire logic bus_data_oe_n,
    input wire logic bus_dav_out,
    input wire logic bus_dav_oe_n,
    input wire logic bus_nrfd_oe_n,
    input wire logic cpu_read,
    input wire logic [EVT_COUNT-1:0] cpu_ack,
    input wire logic [EVT_COUNT-1:0] event_pending,
    input wire logic remote,
    input wire logic talker,
    input wire logic listener,
    input wire logic irq
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    irq_set_a: assert property ((|event_pending) |-> irq)
        else $error("irq missing after event");
    irq_quiet_a: assert property (!(|event_pending) |-> !irq)
        else $error("irq without event");
    dav_talker_a: assert property (!bus_dav_oe_n |-> talker)
        else $error("DAV driven while not talker");
    data_talker_a: assert property (!bus_data_oe_n |-> talker)
        else $error("data driven while not talker");
    dav_ready_a: assert property ($rose(!bus_dav_oe_n && bus_dav_out) |-> !bus_nrfd_in)
        else $error("DAV asserted while not ready");
    full_hold_a: assert property ((event_pending[EVT_DATA_IN] && !bus_atn)[*6] |-> !bus_nrfd_oe_n)
        else $error("NRFD released with input full");
    data_listen_a: assert property ($rose(event_pending[EVT_DATA_IN]) |-> listener)
        else $error("data taken while not listener");
    read_clear_a: assert property (cpu_read |-> ##[1:2] !event_pending[EVT_DATA_IN])
        else $error("read did not clear data event");
    ack_clear_a: assert property (cpu_ack[EVT_POLL] |-> ##[1:2] !event_pending[EVT_POLL])
        else $error("ack did not clear poll event");
    remote_rlc_a: assert property ($changed(remote) |-> ##[0:2] event_pending[EVT_RLC])
        else $error("remote change without event");

    cover property ($rose(event_pending[EVT_DATA_IN]));
    cover property ($rose(event_pending[EVT_DATA_OUT]));
    cover property ($fell(remote));
    cover property ($rose(talker));
endmodule : ibt_tl_sva

bind ibt_talker_listener ibt_tl_sva chk (
    .clk(clk), .reset(reset), .bus_atn(bus_atn), .bus_nrfd_in(bus_nrfd_in),
    .bus_data_oe_n(bus_data_oe_n), .bus_dav_out(bus_dav_out), .bus_dav_oe_n(bus_dav_oe_n),
    .bus_nrfd_oe_n(bus_nrfd_oe_n), .cpu_read(cpu_read), .cpu_ack(cpu_ack),
    .event_pending(event_pending), .remote(remote), .talker(talker),
    .listener(listener), .irq(irq)
);

/* testbench/tb_instrument_bus_talker_listener.sv */
// Purpose: Self-checking bench for the bus talker/listener.
// Assumes: Controller model drives the bus; bench plays the processor.
// Notes: Random bytes and address come from a fixed seed.
`timescale 1ns/10ps
`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            n_fail++; \
            $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
        end \
    end
module tb_instrument_bus_talker_listener
    import ibt_pkg::*;
;
    logic clk, reset, bus_data_oe_n, bus_atn, bus_ren, bus_ifc, bus_dav_in, bus_dav_out;
    logic bus_dav_oe_n, bus_nrfd_in, bus_nrfd_out, bus_nrfd_oe_n, bus_ndac_in;
    logic bus_ndac_out, bus_ndac_oe_n, cpu_read, cpu_write, remote, talker, listener, irq;
    logic [4:0] my_address;
    logic [7:0] bus_data_in, bus_data_out, cpu_data_in, cpu_data_out;
    logic [EVT_COUNT-1:0] cpu_ack, event_pending;
    int seed = 52;
    int n_fail = 0;
    int num_checks = 0;

    ibt_talker_listener dut (
        .clk(clk), .reset(reset), .my_address(my_address), .bus_data_in(bus_data_in),
        .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n), .bus_atn(bus_atn),
        .bus_ren(bus_ren), .bus_ifc(bus_ifc), .bus_dav_in(bus_dav_in),
        .bus_dav_out(bus_dav_out), .bus_dav_oe_n(bus_dav_oe_n), .bus_nrfd_in(bus_nrfd_in),
        .bus_nrfd_out(bus_nrfd_out), .bus_nrfd_oe_n(bus_nrfd_oe_n),
        .bus_ndac_in(bus_ndac_in), .bus_ndac_out(bus_ndac_out),
        .bus_ndac_oe_n(bus_ndac_oe_n), .cpu_read(cpu_read), .cpu_data_in(cpu_data_in),
        .cpu_write(cpu_write), .cpu_data_out(cpu_data_out), .cpu_ack(cpu_ack),
        .event_pending(event_pending), .remote(remote), .talker(talker),
        .listener(listener), .irq(irq)
    );
    ibt_ctrl_model ctl (
        .clk(clk), .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
        .bus_dav_out(bus_dav_out), .bus_dav_oe_n(bus_dav_oe_n), .bus_nrfd_out(bus_nrfd_out),
        .bus_nrfd_oe_n(bus_nrfd_oe_n), .bus_ndac_out(bus_ndac_out),
        .bus_ndac_oe_n(bus_ndac_oe_n), .bus_data_in(bus_data_in), .bus_dav_in(bus_dav_in),
        .bus_nrfd_in(bus_nrfd_in), .bus_ndac_in(bus_ndac_in), .bus_atn(bus_atn),
        .bus_ren(bus_ren), .bus_ifc(bus_ifc)
    );

    function automatic int evt_of(input logic [7:0] c);
        return (c == CMD_GET) ? EVT_TRIGGER : (c == CMD_SPE || c == CMD_SPD) ? EVT_POLL : EVT_CLEAR;
    endfunction : evt_of

    function automatic logic [7:0] addr_byte(input logic talk, input logic [4:0] a);
        return {1'b0, talk, !talk, a};
    endfunction : addr_byte

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    task automatic wait_evt(input int idx);
        int i;
        for (i = 0; i < 60 && event_pending[idx] !== 1'b1; i++) step();
        if (event_pending[idx] !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: no event %h", $time, idx);
            close_out();
        end
    endtask : wait_evt

    task automatic ack(input int idx);
        cpu_ack[idx] = 1'b1;
        step();
        cpu_ack = '0;
        repeat (2) step();
    endtask : ack

    task automatic rd();
        cpu_read = 1'b1;
        step();
        cpu_read = 1'b0;
        repeat (2) step();
    endtask : rd

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        close_out();
    end

    initial begin
        logic [7:0] b, got;
        bit ok;
        logic [7:0] cmds [5] = '{CMD_SDC, CMD_GET, CMD_DCL, CMD_SPE, CMD_SPD};
        reset = 1'b1;
        cpu_read = 1'b0;
        cpu_write = 1'b0;
        cpu_data_out = 8'h00;
        cpu_ack = '0;
        my_address = 5'($unsigned($random(seed)) % 30);
        repeat (5) @(posedge clk);
        #1 reset = 1'b0;
        `CHK({talker, listener, remote, irq}, 4'h0)
        `CHK({bus_data_oe_n, bus_dav_oe_n, bus_nrfd_oe_n, bus_ndac_oe_n}, 4'hf)
        ctl.bus_ren = 1'b1;
        ctl.send(addr_byte(1'b0, my_address + 5'h01), 1'b1, ok);
        `CHK(listener, 1'b0)
        ctl.send(addr_byte(1'b0, my_address), 1'b1, ok);
        wait_evt(EVT_RLC);
        `CHK({listener, remote}, 2'h3)
        ack(EVT_RLC);
        for (int k = 0; k < 8; k++) begin
            b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
            ctl.send(b, 1'b0, ok);
            wait_evt(EVT_DATA_IN);
            step();
            `CHK({irq, cpu_data_in}, {1'b1, b})
            rd();
            `CHK(event_pending[EVT_DATA_IN], 1'b0)
        end
        ctl.send(8'h5a, 1'b0, ok);
        wait_evt(EVT_DATA_IN);
        ctl.send(8'ha5, 1'b0, ok);
        `CHK(ok, 1'b0)
        rd();
        `CHK(cpu_data_in, 8'h5a)
        foreach (cmds[k]) begin
            ctl.send(cmds[k], 1'b1, ok);
            wait_evt(evt_of(cmds[k]));
            `CHK(ok, 1'b1)
            ack(evt_of(cmds[k]));
            `CHK(event_pending[evt_of(cmds[k])], 1'b0)
        end
        ctl.send(CMD_GTL, 1'b1, ok);
        wait_evt(EVT_RLC);
        `CHK(remote, 1'b0)
        ack(EVT_RLC);
        ctl.send(addr_byte(1'b0, my_address), 1'b1, ok);
        wait_evt(EVT_RLC);
        `CHK(remote, 1'b1)
        ack(EVT_RLC);
        ctl.bus_ren = 1'b0;
        wait_evt(EVT_RLC);
        `CHK(remote, 1'b0)
        ack(EVT_RLC);
        ctl.bus_ren = 1'b1;
        ctl.send(CMD_UNL, 1'b1, ok);
        `CHK(listener, 1'b0)
        ctl.send(8'h3c, 1'b0, ok);
        `CHK(event_pending[EVT_DATA_IN], 1'b0)
        ctl.send(addr_byte(1'b1, my_address), 1'b1, ok);
        `CHK(talker, 1'b1)
        ctl.bus_atn = 1'b0;
        // Word handed over after display refresh.
        for (int k = 0; k < 12; k++) begin
            // Nine value bytes, exponent, CR, LF.
            b = (k < 9) ? 8'h30 + 8'($unsigned($random(seed)) % 10)
                : (k == 9) ? 8'h45 : (k == 10) ? 8'h0d : 8'h0a;
            fork
                ctl.recv(got, 3 * (k % 2) + 1, ok);
                begin
                    step();
                    cpu_data_out = b;
                    cpu_write = 1'b1;
                    step();
                    cpu_write = 1'b0;
                end
            join
            `CHK({ok, got}, {1'b1, b})
            wait_evt(EVT_DATA_OUT);
            `CHK(bus_dav_oe_n, 1'b1)
        end
        ctl.send(CMD_UNT, 1'b1, ok);
        `CHK(talker, 1'b0)
        ctl.send(addr_byte(1'b0, my_address), 1'b1, ok);
        wait_evt(EVT_RLC);
        `CHK({listener, remote}, 2'h3)
        ctl.bus_ifc = 1'b1;
        repeat (8) step();
        ctl.bus_ifc = 1'b0;
        `CHK({talker, listener}, 2'h0)
        close_out();
    end
endmodule : tb_instrument_bus_talker_listener
